// [logic/jrxlp_pkg.sv]
package jrxlp_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [11:0] ADDR_L7_RX_SUM = 12'h445;
    localparam logic [11:0] ADDR_L7_CALC_SUM = 12'h446;
    localparam logic [11:0] ADDR_DEV_ID = 12'h450;
    localparam logic [11:0] ADDR_BANK_ADJ = 12'h451;
    localparam logic [11:0] ADDR_LANE0_PH = 12'h452;
    localparam logic [11:0] ADDR_SCR_LANES = 12'h453;
    localparam logic [11:0] ADDR_OCTETS = 12'h454;
    localparam logic [11:0] ADDR_FRAMES_MF = 12'h455;
    localparam logic [11:0] ADDR_CONV_CNT = 12'h456;
    localparam logic [11:0] ADDR_CS_RES = 12'h457;
    localparam logic [11:0] ADDR_SUBCLASS = 12'h458;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_SCR_LANES = 8'h83;
    localparam logic [7:0] RST_FRAMES_MF = 8'h1f;
    localparam logic [7:0] RST_CONV_CNT = 8'h01;
    localparam logic [7:0] RST_CS_RES = 8'h1f;
    localparam logic [7:0] RST_SUBCLASS = 8'h20;

    // ------------------------------------------------------------
    // Writable bit masks (reserved bits read as zero)
    // ------------------------------------------------------------
    localparam logic [7:0] MASK_LANE0_PH = 8'h7f;
    localparam logic [7:0] MASK_SCR_LANES = 8'h9f;
    localparam logic [7:0] MASK_FRAMES_MF = 8'h1f;
    localparam logic [7:0] MASK_CS_RES = 8'hdf;
    localparam logic [7:0] MASK_SUBCLASS = 8'he0;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int POS_DESCR_EN = 7;
    localparam int POS_ADJ_DIR = 6;
    localparam int POS_PH_ADJ = 5;

    // ------------------------------------------------------------
    // Capture states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        JRXLP_IDLE = 2'b01,
        JRXLP_SUM = 2'b10
    } jrxlp_state_t;

endpackage : jrxlp_pkg

// [logic/jrxlp_lane_sum.sv]
`timescale 1ns/1ps
module jrxlp_lane_sum (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ila_start,
    input wire logic ila_valid,
    input wire logic [7:0] ila_octet,
    input wire logic ila_last,
    input wire logic [7:0] ila_rx_sum,
    input wire logic sum_mode,
    output logic sum_done,
    output logic [7:0] rx_sum,
    output logic [7:0] calc_sum
);
    jrxlp_pkg::jrxlp_state_t state_reg, state_next;
    logic [7:0] acc_reg;
    logic [7:0] acc_next;
    wire logic [7:0] term;

    // Method 1 sums whole octets; method 0 sums the low nibble of each octet
    assign term = sum_mode ? ila_octet : {4'h0, ila_octet[3:0]};
    assign acc_next = acc_reg + term;

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            jrxlp_pkg::JRXLP_IDLE: if (ila_start) state_next = jrxlp_pkg::JRXLP_SUM;
            jrxlp_pkg::JRXLP_SUM: if (ila_valid && ila_last) state_next = jrxlp_pkg::JRXLP_IDLE;
            default: state_next = jrxlp_pkg::JRXLP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= jrxlp_pkg::JRXLP_IDLE;
            acc_reg <= jrxlp_pkg::RST_ZERO;
            sum_done <= 1'b0;
            rx_sum <= jrxlp_pkg::RST_ZERO;
            calc_sum <= jrxlp_pkg::RST_ZERO;
        end else begin
            state_reg <= state_next;
            sum_done <= 1'b0;
            if (state_reg == jrxlp_pkg::JRXLP_IDLE && ila_start) begin
                acc_reg <= jrxlp_pkg::RST_ZERO;
            end else if (state_reg == jrxlp_pkg::JRXLP_SUM && ila_valid) begin
                acc_reg <= acc_next;
                if (ila_last) begin
                    rx_sum <= ila_rx_sum;
                    calc_sum <= acc_next;
                    sum_done <= 1'b1;
                end
            end
        end
    end
endmodule : jrxlp_lane_sum

// [logic/jrxlp_regs.sv]
`timescale 1ns/1ps
module jrxlp_regs (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [11:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic checksum_method_select,
    input wire logic ila_start,
    input wire logic ila_valid,
    input wire logic [7:0] ila_octet,
    input wire logic ila_last,
    input wire logic [7:0] ila_rx_sum,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    output logic descramble_en,
    output logic [4:0] lane_count_code,
    output logic [4:0] frames_mf_code,
    output logic phase_adj_req,
    output logic adj_dir,
    output logic [3:0] adj_res,
    output logic lane7_sum_update
);
    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    logic [7:0] dev_id_reg;
    logic [7:0] bank_adj_reg;
    logic [7:0] lane0_ph_reg;
    logic [7:0] scr_lanes_reg;
    logic [7:0] octets_reg;
    logic [7:0] frames_mf_reg;
    logic [7:0] cs_res_reg;
    logic [7:0] subclass_reg;
    logic [7:0] rdata_next;
    wire logic [7:0] lane7_rx_checksum_value;
    wire logic [7:0] lane7_calc_checksum_value;
    wire logic sum_done;

    // ------------------------------------------------------------
    // Checksum capture
    // ------------------------------------------------------------
    jrxlp_lane_sum u_sum (
        .clk(clk),
        .rst_n(rst_n),
        .ila_start(ila_start),
        .ila_valid(ila_valid),
        .ila_octet(ila_octet),
        .ila_last(ila_last),
        .ila_rx_sum(ila_rx_sum),
        .sum_mode(checksum_method_select),
        .sum_done(sum_done),
        .rx_sum(lane7_rx_checksum_value),
        .calc_sum(lane7_calc_checksum_value)
    );

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    // Strobe aimed at one register offset; all operands are arguments so callers stay sensitive to them
    function automatic logic hit(input logic strobe, input logic [11:0] addr, input logic [11:0] target);
        return strobe && addr == target;
    endfunction : hit

    wire logic wr_dev = hit(reg_wr, reg_addr, jrxlp_pkg::ADDR_DEV_ID);
    wire logic wr_bank = hit(reg_wr, reg_addr, jrxlp_pkg::ADDR_BANK_ADJ);
    wire logic wr_lane0 = hit(reg_wr, reg_addr, jrxlp_pkg::ADDR_LANE0_PH);
    wire logic wr_scr = hit(reg_wr, reg_addr, jrxlp_pkg::ADDR_SCR_LANES);
    wire logic wr_oct = hit(reg_wr, reg_addr, jrxlp_pkg::ADDR_OCTETS);
    wire logic wr_kmf = hit(reg_wr, reg_addr, jrxlp_pkg::ADDR_FRAMES_MF);
    wire logic wr_csn = hit(reg_wr, reg_addr, jrxlp_pkg::ADDR_CS_RES);
    wire logic wr_sub = hit(reg_wr, reg_addr, jrxlp_pkg::ADDR_SUBCLASS);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            dev_id_reg <= jrxlp_pkg::RST_ZERO;
            bank_adj_reg <= jrxlp_pkg::RST_ZERO;
            lane0_ph_reg <= jrxlp_pkg::RST_ZERO;
            scr_lanes_reg <= jrxlp_pkg::RST_SCR_LANES;
            octets_reg <= jrxlp_pkg::RST_ZERO;
            frames_mf_reg <= jrxlp_pkg::RST_FRAMES_MF;
            cs_res_reg <= jrxlp_pkg::RST_CS_RES;
            subclass_reg <= jrxlp_pkg::RST_SUBCLASS;
        end else begin
            if (wr_dev) dev_id_reg <= reg_wdata;
            if (wr_bank) bank_adj_reg <= reg_wdata;
            if (wr_lane0) lane0_ph_reg <= reg_wdata & jrxlp_pkg::MASK_LANE0_PH;
            if (wr_scr) scr_lanes_reg <= reg_wdata & jrxlp_pkg::MASK_SCR_LANES;
            if (wr_oct) octets_reg <= reg_wdata;
            if (wr_kmf) frames_mf_reg <= reg_wdata & jrxlp_pkg::MASK_FRAMES_MF;
            if (wr_csn) cs_res_reg <= reg_wdata & jrxlp_pkg::MASK_CS_RES;
            if (wr_sub) subclass_reg <= reg_wdata & jrxlp_pkg::MASK_SUBCLASS;
        end
    end

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    // Unmapped offsets and reserved bits read as zero
    always_comb begin
        case (reg_addr)
            jrxlp_pkg::ADDR_L7_RX_SUM: rdata_next = lane7_rx_checksum_value;
            jrxlp_pkg::ADDR_L7_CALC_SUM: rdata_next = lane7_calc_checksum_value;
            jrxlp_pkg::ADDR_DEV_ID: rdata_next = dev_id_reg;
            jrxlp_pkg::ADDR_BANK_ADJ: rdata_next = bank_adj_reg;
            jrxlp_pkg::ADDR_LANE0_PH: rdata_next = lane0_ph_reg;
            jrxlp_pkg::ADDR_SCR_LANES: rdata_next = scr_lanes_reg;
            jrxlp_pkg::ADDR_OCTETS: rdata_next = octets_reg;
            jrxlp_pkg::ADDR_FRAMES_MF: rdata_next = frames_mf_reg;
            jrxlp_pkg::ADDR_CONV_CNT: rdata_next = jrxlp_pkg::RST_CONV_CNT;
            jrxlp_pkg::ADDR_CS_RES: rdata_next = cs_res_reg;
            jrxlp_pkg::ADDR_SUBCLASS: rdata_next = subclass_reg;
            default: rdata_next = jrxlp_pkg::RST_ZERO;
        endcase
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= jrxlp_pkg::RST_ZERO;
            reg_rvalid <= 1'b0;
            descramble_en <= jrxlp_pkg::RST_SCR_LANES[jrxlp_pkg::POS_DESCR_EN];
            lane_count_code <= jrxlp_pkg::RST_SCR_LANES[4:0];
            frames_mf_code <= jrxlp_pkg::RST_FRAMES_MF[4:0];
            phase_adj_req <= jrxlp_pkg::RST_ZERO[jrxlp_pkg::POS_PH_ADJ];
            adj_dir <= jrxlp_pkg::RST_ZERO[jrxlp_pkg::POS_ADJ_DIR];
            adj_res <= jrxlp_pkg::RST_ZERO[7:4];
            lane7_sum_update <= 1'b0;
        end else begin
            reg_rdata <= reg_rd ? rdata_next : jrxlp_pkg::RST_ZERO;
            reg_rvalid <= reg_rd;
            descramble_en <= scr_lanes_reg[jrxlp_pkg::POS_DESCR_EN];
            lane_count_code <= scr_lanes_reg[4:0];
            frames_mf_code <= frames_mf_reg[4:0];
            phase_adj_req <= lane0_ph_reg[jrxlp_pkg::POS_PH_ADJ];
            adj_dir <= lane0_ph_reg[jrxlp_pkg::POS_ADJ_DIR];
            adj_res <= bank_adj_reg[7:4];
            lane7_sum_update <= sum_done;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    // Checksums move only on the edge that also raises sum_done
    property p_rx_sum_hold;
        @(posedge clk) disable iff (!rst_n)
        !sum_done |-> $stable(lane7_rx_checksum_value);
    endproperty
    a_rx_sum_hold: assert property (p_rx_sum_hold) else $error("rx checksum changed without capture");

    property p_calc_hold;
        @(posedge clk) disable iff (!rst_n)
        !sum_done |-> $stable(lane7_calc_checksum_value);
    endproperty
    a_calc_hold: assert property (p_calc_hold) else $error("calc checksum changed without capture");

    property p_update_follows;
        @(posedge clk) disable iff (!rst_n)
        sum_done |=> lane7_sum_update;
    endproperty
    a_update_follows: assert property (p_update_follows) else $error("update pulse missing");

    property p_descr;
        @(posedge clk) disable iff (!rst_n)
        wr_scr |=> ##1 descramble_en == $past(reg_wdata[7], 2);
    endproperty
    a_descr: assert property (p_descr) else $error("descramble enable wrong");

    property p_lanes;
        @(posedge clk) disable iff (!rst_n)
        wr_scr |=> ##1 lane_count_code == $past(reg_wdata[4:0], 2);
    endproperty
    a_lanes: assert property (p_lanes) else $error("lane count wrong");

    property p_kmf;
        @(posedge clk) disable iff (!rst_n)
        wr_kmf |=> ##1 frames_mf_code == $past(reg_wdata[4:0], 2);
    endproperty
    a_kmf: assert property (p_kmf) else $error("frames per multiframe wrong");

    property p_conv_ro;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == jrxlp_pkg::ADDR_CONV_CNT |=> reg_rdata == 8'h01;
    endproperty
    a_conv_ro: assert property (p_conv_ro) else $error("converter count not one");

    property p_phadj;
        @(posedge clk) disable iff (!rst_n)
        wr_lane0 |=> ##1 phase_adj_req == $past(reg_wdata[5], 2) && adj_dir == $past(reg_wdata[6], 2);
    endproperty
    a_phadj: assert property (p_phadj) else $error("phase adjust fields wrong");

    property p_res;
        @(posedge clk) disable iff (!rst_n)
        wr_bank |=> ##1 adj_res == $past(reg_wdata[7:4], 2);
    endproperty
    a_res: assert property (p_res) else $error("adjust resolution wrong");

    property p_sub_rb;
        @(posedge clk) disable iff (!rst_n)
        wr_sub ##1 !wr_sub ##1 (reg_rd && reg_addr == jrxlp_pkg::ADDR_SUBCLASS && !reg_wr)
            |=> reg_rdata == ($past(reg_wdata, 3) & jrxlp_pkg::MASK_SUBCLASS);
    endproperty
    a_sub_rb: assert property (p_sub_rb) else $error("subclass readback wrong");

    property p_rx_capture;
        @(posedge clk) disable iff (!rst_n)
        sum_done |-> lane7_rx_checksum_value == $past(ila_rx_sum);
    endproperty
    a_rx_capture: assert property (p_rx_capture) else $error("rx checksum not taken from last octet");

    property p_update_pulse;
        @(posedge clk) disable iff (!rst_n)
        lane7_sum_update |=> !lane7_sum_update;
    endproperty
    a_update_pulse: assert property (p_update_pulse) else $error("update pulse longer than one cycle");

    property p_oct_no_effect;
        @(posedge clk) disable iff (!rst_n)
        wr_oct |=> ##1 $stable(descramble_en) && $stable(lane_count_code)
            && $stable(frames_mf_code) && $stable(adj_res);
    endproperty
    a_oct_no_effect: assert property (p_oct_no_effect) else $error("octets write moved a mirror");

    property p_kmf_rsvd;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == jrxlp_pkg::ADDR_FRAMES_MF |=> reg_rdata[7:5] == 3'h0;
    endproperty
    a_kmf_rsvd: assert property (p_kmf_rsvd) else $error("frames reserved bits not zero");

    property p_lane0_rsvd;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == jrxlp_pkg::ADDR_LANE0_PH |=> !reg_rdata[7];
    endproperty
    a_lane0_rsvd: assert property (p_lane0_rsvd) else $error("lane0 reserved bit not zero");

    property p_scr_rsvd;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == jrxlp_pkg::ADDR_SCR_LANES |=> reg_rdata[6:5] == 2'h0;
    endproperty
    a_scr_rsvd: assert property (p_scr_rsvd) else $error("lane count reserved bits not zero");

    property p_sub_rsvd;
        @(posedge clk) disable iff (!rst_n)
        reg_rd && reg_addr == jrxlp_pkg::ADDR_SUBCLASS |=> reg_rdata[4:0] == 5'h00;
    endproperty
    a_sub_rsvd: assert property (p_sub_rsvd) else $error("subclass low bits not zero");

    property p_lane0_id;
        @(posedge clk) disable iff (!rst_n)
        wr_lane0 ##1 !wr_lane0 ##1 (reg_rd && reg_addr == jrxlp_pkg::ADDR_LANE0_PH)
            |=> reg_rdata[4:0] == $past(reg_wdata[4:0], 3);
    endproperty
    a_lane0_id: assert property (p_lane0_id) else $error("lane0 identity readback wrong");

    // ------------------------------------------------------------
    // Reset checks
    // ------------------------------------------------------------
    property p_rst_mirrors;
        @(posedge clk)
        !rst_n |=> descramble_en && lane_count_code == 5'h03;
    endproperty
    a_rst_mirrors: assert property (p_rst_mirrors) else $error("mirror reset value wrong");

    property p_rst_sums;
        @(posedge clk)
        !rst_n |=> lane7_rx_checksum_value == 8'h00 && lane7_calc_checksum_value == 8'h00;
    endproperty
    a_rst_sums: assert property (p_rst_sums) else $error("checksum reset value wrong");

    // ------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------
    c_capture: cover property (@(posedge clk) disable iff (!rst_n) lane7_sum_update);
    c_scr_off: cover property (@(posedge clk) disable iff (!rst_n) !descramble_en);
    c_read_sum: cover property (@(posedge clk) disable iff (!rst_n) reg_rd && reg_addr == jrxlp_pkg::ADDR_L7_CALC_SUM);
    c_nibble_sum: cover property (@(posedge clk) disable iff (!rst_n) sum_done && !checksum_method_select);
    c_kmf16: cover property (@(posedge clk) disable iff (!rst_n) frames_mf_code == 5'h0f);
endmodule : jrxlp_regs

// [sim/jrxlp_tx_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Lane 7 transmitter model: sends one link-information block
// ------------------------------------------------------------
module jrxlp_tx_model (
    input wire logic clk,
    output logic ila_start,
    output logic ila_valid,
    output logic [7:0] ila_octet,
    output logic ila_last,
    output logic [7:0] ila_rx_sum
);
    initial begin
        ila_start = 1'b0;
        ila_valid = 1'b0;
        ila_octet = 8'h5a;
        ila_last = 1'b0;
        ila_rx_sum = 8'ha5;
    end

    // Octets are base, base+1 ...; each idle cycle inverts the octet bus, so every second one shows the last octet again
    task automatic send(input logic [7:0] base, input int n, input int gap, input logic [7:0] sum);
        @(posedge clk);
        ila_start <= 1'b1;
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            ila_start <= 1'b0;
            ila_valid <= 1'b1;
            ila_octet <= base + 8'(i);
            ila_last <= (i == n - 1);
            ila_rx_sum <= (i == n - 1) ? sum : ~sum;
            for (int g = 0; g < gap && i < n - 1; g++) begin
                @(posedge clk);
                ila_valid <= 1'b0;
                ila_octet <= ~ila_octet;
            end
        end
        @(posedge clk);
        ila_valid <= 1'b0;
        ila_last <= 1'b0;
        ila_octet <= ~ila_octet;
        ila_rx_sum <= ~ila_rx_sum;
    endtask : send
endmodule : jrxlp_tx_model

// [sim/tb_top.sv]
`timescale 1ns/1ps
module tb_top;
    typedef struct {logic [11:0] a; logic [7:0] rv; logic [7:0] wd; logic [7:0] ex;} jrxlp_row_t;
    logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, checksum_method_select = 1'b1;
    logic [11:0] reg_addr = 12'h000;
    logic [7:0] reg_wdata = 8'h00;
    logic ila_start, ila_valid, ila_last, reg_rvalid, descramble_en, phase_adj_req, adj_dir, lane7_sum_update;
    logic [7:0] ila_octet, ila_rx_sum, reg_rdata;
    logic [4:0] lane_count_code, frames_mf_code;
    logic [3:0] adj_res;
    int fails = 0;
    int check_count = 0;
    jrxlp_row_t rows[12] = '{
        '{12'h445, 8'h00, 8'hff, 8'h00},
        '{12'h446, 8'h00, 8'hff, 8'h00},
        '{12'h450, 8'h00, 8'ha5, 8'ha5},
        '{12'h451, 8'h00, 8'hc7, 8'hc7},
        '{12'h452, 8'h00, 8'hff, 8'h7f},
        '{12'h453, 8'h83, 8'h61, 8'h01},
        '{12'h454, 8'h00, 8'h02, 8'h02},
        '{12'h455, 8'h1f, 8'hef, 8'h0f},
        '{12'h456, 8'h01, 8'hff, 8'h01},
        '{12'h457, 8'h1f, 8'h2f, 8'h0f},
        '{12'h458, 8'h20, 8'hff, 8'he0},
        '{12'h400, 8'h00, 8'hff, 8'h00}
    };

    always #5 clk = ~clk;

    jrxlp_tx_model i_tx (.clk(clk), .ila_start(ila_start), .ila_valid(ila_valid), .ila_octet(ila_octet),
        .ila_last(ila_last), .ila_rx_sum(ila_rx_sum));
    jrxlp_regs i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .checksum_method_select(checksum_method_select), .ila_start(ila_start),
        .ila_valid(ila_valid), .ila_octet(ila_octet), .ila_last(ila_last), .ila_rx_sum(ila_rx_sum),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .descramble_en(descramble_en),
        .lane_count_code(lane_count_code), .frames_mf_code(frames_mf_code), .phase_adj_req(phase_adj_req),
        .adj_dir(adj_dir), .adj_res(adj_res), .lane7_sum_update(lane7_sum_update));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr

    task automatic rd(input logic [11:0] a, input logic [7:0] exp, input string name);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1;
        chk("reg_rvalid", 8'h01, {7'h00, reg_rvalid});
        chk(name, exp, reg_rdata);
    endtask : rd

    function automatic logic [7:0] exp_sum(input logic [7:0] base, input int n, input logic whole);
        logic [7:0] s;
        logic [7:0] o;
        s = 8'h00;
        for (int i = 0; i < n; i++) begin
            o = base + 8'(i);
            s = s + (whole ? o : {4'h0, o[3:0]});
        end
        return s;
    endfunction : exp_sum

    // Capture one block and compare both lane 7 checksum registers
    task automatic capture(input logic m, input logic [7:0] base, input int n, input int gap,
                           input logic [7:0] sum);
        int k;
        @(posedge clk);
        checksum_method_select <= m;
        i_tx.send(base, n, gap, sum);
        k = 0;
        while (lane7_sum_update !== 1'b1 && k < 6) begin
            @(posedge clk);
            #1;
            k++;
        end
        chk("lane7_sum_update", 8'h01, {7'h00, lane7_sum_update});
        rd(12'h445, sum, "lane7_received_checksum");
        rd(12'h446, exp_sum(base, n, m), "lane7_computed_checksum");
    endtask : capture

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : end_of_test

    // ------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------
    initial begin
        #200us;
        fails++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        foreach (rows[i]) begin
            rd(rows[i].a, rows[i].rv, "reset value");
            wr(rows[i].a, rows[i].wd);
            rd(rows[i].a, rows[i].ex, "readback");
        end
        $display("test register table done");
        wr(12'h453, 8'h07);
        @(posedge clk);
        #1;
        chk("descramble_en", 8'h00, {7'h00, descramble_en});
        chk("lane_count_code", 8'h07, {3'h0, lane_count_code});
        wr(12'h452, 8'h40);
        wr(12'h451, 8'h90);
        wr(12'h455, 8'h1f);
        @(posedge clk);
        #1;
        chk("adj_dir", 8'h01, {7'h00, adj_dir});
        chk("phase_adj_req", 8'h00, {7'h00, phase_adj_req});
        chk("adj_res", 8'h09, {4'h0, adj_res});
        chk("frames_mf_code", 8'h1f, {3'h0, frames_mf_code});
        wr(12'h454, 8'hff);
        @(posedge clk);
        #1;
        chk("mirror after octets write", 8'h1e, {descramble_en, lane_count_code, adj_dir, phase_adj_req});
        $display("test mirrors done");
        capture(1'b1, 8'hf0, 5, 0, 8'h3c);
        capture(1'b0, 8'h1e, 7, 2, 8'hc4);
        repeat (4) @(posedge clk);
        #1;
        chk("held checksum", 8'h00, {7'h00, lane7_sum_update});
        rd(12'h445, 8'hc4, "lane7_received_checksum held");
        $display("test capture done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk("descramble_en after reset", 8'h01, {7'h00, descramble_en});
        rd(12'h445, 8'h00, "lane7_received_checksum after reset");
        rd(12'h446, 8'h00, "lane7_computed_checksum after reset");
        rd(12'h458, 8'h20, "subclass after reset");
        $display("test second reset done");
        end_of_test();
    end
endmodule : tb_top
